// File: bench/fp_issue_model.sv
// issuing pipeline model
`timescale 1ns/1ps
module fp_issue_model (
  input  wire logic   core_clk,
  output logic        issue_valid,
  output logic [31:0] instr_word,
  output logic [63:0] fs_value,
  output logic [63:0] ft_value,
  output logic [63:0] fr_value,
  output logic        fpu_enabled,
  output logic [1:0]  round_mode
);
  initial begin
    issue_valid = 1'b0;
    instr_word  = 32'h0;
    fs_value    = 64'h0;
    ft_value    = 64'h0;
    fr_value    = 64'h0;
    fpu_enabled = 1'b1;
    round_mode  = 2'h0;
  end
  // full register mode; operands in named format
  task automatic send(input logic [31:0] w, input logic [63:0] s, t, r,
                      input logic en, input logic [1:0] rm);
    issue_valid = 1'b1;
    instr_word  = w;
    fs_value    = s;
    ft_value    = t;
    fr_value    = r;
    fpu_enabled = en;
    round_mode  = rm;
    @(negedge core_clk);
  endtask
  // idle bus shows inverted leftovers
  task automatic stop();
    issue_valid = 1'b0;
    instr_word  = ~instr_word;
    fs_value    = ~fs_value;
    ft_value    = ~ft_value;
    fr_value    = ~fr_value;
  endtask
endmodule

// File: bench/fp_negate_and_negative_fused_ops_test.sv
// self-checking bench for the datapath
`timescale 1ns/1ps
module fp_negate_and_negative_fused_ops_test;
  import fp_negfused_pkg::*;
  logic        core_clk = 1'b0, srst = 1'b1, issue_valid, fpu_enabled;
  logic [31:0] instr_word;
  logic [63:0] fs_value, ft_value, fr_value, result_value;
  logic [1:0]  round_mode;
  logic [4:0]  trap_enable = 5'h0, flag_clear = 5'h0, result_dest, sticky_flags;
  logic [5:0]  cause_bits;
  logic        result_valid, fp_trap, cop_unusable_exc, reserved_instr_exc;
  int          n_mismatch = 0, compares = 0, cycles = 0;
  always #12.5 core_clk = ~core_clk;
  fp_issue_model core (.core_clk(core_clk), .issue_valid(issue_valid),
    .instr_word(instr_word), .fs_value(fs_value), .ft_value(ft_value),
    .fr_value(fr_value), .fpu_enabled(fpu_enabled), .round_mode(round_mode));
  fp_negate_and_negative_fused_ops uut (.core_clk(core_clk), .srst(srst),
    .issue_valid(issue_valid), .instr_word(instr_word), .fs_value(fs_value),
    .ft_value(ft_value), .fr_value(fr_value), .fpu_enabled(fpu_enabled),
    .round_mode(round_mode), .trap_enable(trap_enable), .flag_clear(flag_clear),
    .result_valid(result_valid), .result_value(result_value), .result_dest(result_dest),
    .cause_bits(cause_bits), .fp_trap(fp_trap), .cop_unusable_exc(cop_unusable_exc),
    .reserved_instr_exc(reserved_instr_exc), .sticky_flags(sticky_flags));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk_v(input string nm, input logic [63:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_s(input string nm, input logic [5:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] fw(input logic [2:0] fn, input logic [2:0] fm);
    return {FUSED_MAJOR, 5'h3, 5'h2, 5'h1, 5'h4, fn, fm};
  endfunction
  function automatic logic [31:0] nw(input logic [4:0] fm);
    return {COP1_MAJOR, fm, 5'h0, 5'h1, 5'h5, NEG_FUNCT};
  endfunction
  task automatic look(input logic [63:0] ev, input logic [5:0] ec, input logic [3:0] eo);
    chk_v("result", ev, result_value);
    chk_s("cause", ec, cause_bits);
    chk_s("outcome", {2'h0, eo},
          {2'h0, result_valid, fp_trap, cop_unusable_exc, reserved_instr_exc});
  endtask
  task automatic op(input logic [31:0] w, input logic [63:0] s, t, r, input logic en,
                    input logic [1:0] rm, input logic [63:0] ev, input logic [5:0] ec,
                    input logic [3:0] eo);
    core.send(w, s, t, r, en, rm);
    core.stop();
    @(negedge core_clk);
    look(ev, ec, eo);
  endtask
  task automatic t_neg();
    op(nw(FMT5_S), 64'h7FC00000, 64'h0, 64'h0, 1, RM_NEAR, 64'hFFC00000, 6'h10, 4'h8);
    op(nw(FMT5_D), 64'h4000000000000000, 64'h0, 64'h0, 1, RM_NEAR,
       64'hC000000000000000, 6'h00, 4'h8);
    op(nw(FMT5_PS), 64'h3F800000_7FC00000, 64'h0, 64'h0, 1, RM_NEAR,
       64'hBF800000_FFC00000, 6'h10, 4'h8);
    chk_s("sticky", 6'h10, {1'b0, sticky_flags});
    $display("t_neg done");
  endtask
  task automatic t_fused();
    op(fw(FN_NMADD, FMT3_S), 64'h40000000, 64'h40400000, 64'h3F800000, 1, RM_NEAR,
       64'hC0E00000, 6'h00, 4'h8);
    op(fw(FN_NMSUB, FMT3_S), 64'h40000000, 64'h40400000, 64'h3F800000, 1, RM_NEAR,
       64'hC0A00000, 6'h00, 4'h8);
    op(fw(FN_NMADD, FMT3_D), 64'h4000000000000000, 64'h4008000000000000,
       64'h3FF0000000000000, 1, RM_NEAR, 64'hC01C000000000000, 6'h00, 4'h8);
    op(fw(FN_NMSUB, FMT3_PS), 64'h40000000_3F800000, 64'h40400000_3F800000,
       64'h3F800000_40800000, 1, RM_NEAR, 64'hC0A00000_40400000, 6'h00, 4'h8);
    $display("t_fused done");
  endtask
  task automatic t_round();
    op(fw(FN_NMADD, FMT3_S), 64'h3F800001, 64'h3F800001, 64'hBF800000, 1, RM_NEAR,
       64'hB4800000, 6'h01, 4'h8);
    op(fw(FN_NMSUB, FMT3_S), 64'h3F800001, 64'h3F800001, 64'h3F800000, 1, RM_NEAR,
       64'hB4800000, 6'h01, 4'h8);
    chk_s("sticky", 6'h11, {1'b0, sticky_flags});
    $display("t_round done");
  endtask
  task automatic t_flags();
    flag_clear = 5'h1F;
    @(negedge core_clk);
    flag_clear = 5'h0;
    chk_s("sticky", 6'h00, {1'b0, sticky_flags});
    trap_enable = 5'h01;
    op(fw(FN_NMADD, FMT3_S), 64'h3F800001, 64'h3F800001, 64'hBF800000, 1, RM_NEAR,
       64'hB4800000, 6'h01, 4'h4);
    chk_s("sticky", 6'h00, {1'b0, sticky_flags});
    trap_enable = 5'h0;
    $display("t_flags done");
  endtask
  task automatic t_ovf();
    op(fw(FN_NMADD, FMT3_S), 64'h7F7FFFFF, 64'h40000000, 64'h0, 1, RM_NEAR,
       64'hFF800000, 6'h05, 4'h8);
    op(fw(FN_NMADD, FMT3_S), 64'h7F7FFFFF, 64'h40000000, 64'h0, 1, RM_ZERO,
       64'hFF7FFFFF, 6'h05, 4'h8);
    chk_s("sticky", 6'h05, {1'b0, sticky_flags});
    $display("t_ovf done");
  endtask
  task automatic t_exc();
    op(fw(FN_NMADD, FMT3_S), 64'h40000000, 64'h40000000, 64'h0, 0, RM_NEAR,
       64'hFF7FFFFF, 6'h05, 4'h2);
    op(fw(FN_NMSUB, 3'h2), 64'h40000000, 64'h40000000, 64'h0, 1, RM_NEAR,
       64'hFF7FFFFF, 6'h05, 4'h1);
    op(nw(5'h12), 64'h40000000, 64'h0, 64'h0, 1, RM_NEAR, 64'hFF7FFFFF, 6'h05, 4'h1);
    op(32'h0, 64'h40000000, 64'h0, 64'h0, 1, RM_NEAR, 64'hFF7FFFFF, 6'h05, 4'h0);
    chk_s("sticky", 6'h05, {1'b0, sticky_flags});
    $display("t_exc done");
  endtask
  task automatic t_b2b();
    core.send(fw(FN_NMADD, FMT3_S), 64'h40000000, 64'h40400000, 64'h3F800000, 1, RM_NEAR);
    core.send(nw(FMT5_S), 64'h3F800000, 64'h0, 64'h0, 1, RM_NEAR);
    core.stop();
    look(64'hC0E00000, 6'h00, 4'h8);
    @(negedge core_clk);
    look(64'hBF800000, 6'h00, 4'h8);
    $display("t_b2b done");
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    t_neg();
    t_fused();
    t_round();
    t_flags();
    t_ovf();
    t_exc();
    t_b2b();
    complete_run();
  end
endmodule

// File: bench/fp_negfused_checker.sv
// concurrent checks for the datapath
`timescale 1ns/1ps
module fp_negfused_checker
  import fp_negfused_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] fs_value,
  input wire logic        fpu_enabled,
  input wire logic [4:0]  flag_clear,
  input wire logic        result_valid,
  input wire logic [63:0] result_value,
  input wire logic [4:0]  result_dest,
  input wire logic [5:0]  cause_bits,
  input wire logic        fp_trap,
  input wire logic        cop_unusable_exc,
  input wire logic        reserved_instr_exc,
  input wire logic [4:0]  sticky_flags
);
  logic [1:0]  v_q, n_q, e_q, k_q;
  logic [4:0]  d_q [2];
  logic [63:0] x_q [2];
  wire logic [2:0]  f3 = instr_word[2:0];
  wire logic [4:0]  f5 = instr_word[25:21];
  wire logic        fus = instr_word[31:26] == FUSED_MAJOR && instr_word[5:4] == 2'h3;
  wire logic        ngo = instr_word[31:26] == COP1_MAJOR && instr_word[5:0] == NEG_FUNCT;
  wire logic        ok = fus ? (f3 == FMT3_S || f3 == FMT3_D || f3 == FMT3_PS)
                             : (f5 == FMT5_S || f5 == FMT5_D || f5 == FMT5_PS);
  wire logic [63:0] nx = f5 == FMT5_S ? {32'h0, ~fs_value[31], fs_value[30:0]}
    : fs_value ^ (f5 == FMT5_D ? 64'h8000_0000_0000_0000 : 64'h8000_0000_8000_0000);
  wire logic [3:0]  outs = {result_valid, fp_trap, cop_unusable_exc, reserved_instr_exc};
  always_ff @(posedge core_clk) begin
    if (srst) begin
      v_q <= 2'h0;
    end else begin
      v_q <= {v_q[0], issue_valid && (fus || ngo)};
    end
  end
  always_ff @(posedge core_clk) begin
    n_q <= {n_q[0], ngo};
    e_q <= {e_q[0], fpu_enabled};
    k_q <= {k_q[0], ok};
    d_q <= '{instr_word[10:6], d_q[0]};
    x_q <= '{nx, x_q[0]};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_lat; |outs |-> v_q[1]; endproperty
  a_lat: assert property (p_lat) else $error("outcome without an op");
  property p_one; v_q[1] |-> $onehot(outs); endproperty
  a_one: assert property (p_one) else $error("not exactly one outcome");
  property p_cop; v_q[1] && !e_q[1] |-> cop_unusable_exc; endproperty
  a_cop: assert property (p_cop) else $error("disabled unit not refused");
  property p_resv; v_q[1] && e_q[1] && !k_q[1] |-> reserved_instr_exc; endproperty
  a_resv: assert property (p_resv) else $error("bad format not reserved");
  property p_good; v_q[1] && e_q[1] && k_q[1] |-> result_valid || fp_trap; endproperty
  a_good: assert property (p_good) else $error("valid format not executed");
  property p_set;
    result_valid |-> sticky_flags == (($past(sticky_flags) & ~$past(flag_clear)) | cause_bits[4:0]);
  endproperty
  a_set: assert property (p_set) else $error("causes not ORed into flags");
  property p_hold;
    !result_valid |-> sticky_flags == ($past(sticky_flags) & ~$past(flag_clear));
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved without a result");
  property p_negv; result_valid && n_q[1] |-> result_value == x_q[1]; endproperty
  a_negv: assert property (p_negv) else $error("sign flip result wrong");
  property p_negc; (result_valid || fp_trap) && n_q[1] |-> cause_bits[3:0] == 4'h0; endproperty
  a_negc: assert property (p_negc) else $error("sign flip foreign cause");
  property p_dest; result_valid |-> result_dest == d_q[1]; endproperty
  a_dest: assert property (p_dest) else $error("destination field wrong");
  property p_keep;
    cop_unusable_exc || reserved_instr_exc |-> $stable(result_value) && $stable(cause_bits);
  endproperty
  a_keep: assert property (p_keep) else $error("refused op changed data");
endmodule
bind fp_negate_and_negative_fused_ops fp_negfused_checker chk (
  .core_clk(core_clk), .srst(srst), .issue_valid(issue_valid), .instr_word(instr_word),
  .fs_value(fs_value), .fpu_enabled(fpu_enabled), .flag_clear(flag_clear),
  .result_valid(result_valid), .result_value(result_value),
  .result_dest(result_dest), .cause_bits(cause_bits), .fp_trap(fp_trap),
  .cop_unusable_exc(cop_unusable_exc), .reserved_instr_exc(reserved_instr_exc),
  .sticky_flags(sticky_flags)
);

// File: hdl/fp_classify_unit.sv
// splits a floating-point value into fields and classes
`timescale 1ns/1ps
module fp_classify_unit #(
  parameter int EW = 8,
  parameter int FW = 23
) (
  input  wire logic [EW+FW:0] value,
  output logic              sign,
  output logic [EW-1:0]     exp,
  output logic [FW:0]       mant,
  output logic              is_zero,
  output logic              is_inf,
  output logic              is_nan,
  output logic              is_snan,
  output logic              is_denorm
);
  logic exp_max;
  logic exp_min;
  logic frac_nz;

  assign sign      = value[EW+FW];
  assign exp       = value[FW +: EW];
  assign exp_max   = &value[FW +: EW];
  assign exp_min   = ~|value[FW +: EW];
  assign frac_nz   = |value[FW-1:0];
  assign mant      = {~exp_min, value[FW-1:0]};
  assign is_zero   = exp_min & ~frac_nz;
  assign is_denorm = exp_min & frac_nz;
  assign is_inf    = exp_max & ~frac_nz;
  assign is_nan    = exp_max & frac_nz;
  assign is_snan   = exp_max & frac_nz & ~value[FW-1];
endmodule

// File: hdl/fp_negate_and_negative_fused_ops.sv
// negate and negative multiply-add/subtract datapath slice
// Functional notes
// - sign-flip inverts only the sign bit, exponent and fraction kept
// - sign-flip of a NaN raises invalid; only E and V possible
// - paired sign-flip negates both halves, causes ORed
// - major 010011, function 110 at 5..3 selects negative multiply-add
// - same layout, function 111 selects negative multiply-subtract
// - multiply-add: round product, add addend, round, flip sign
// - multiply-subtract: round product, subtract addend, round, flip sign
// - multiply-add results and flags equal separate ops, two roundings
// - multiply-subtract results and flags equal separate ops
// - paired fused ops work per half, causes ORed
// - without trap, cause bits ORed into sticky flags
// - unit disabled gives coprocessor unusable; bad format reserved
// - fused ops raise inexact, unimplemented, invalid, overflow, underflow
// - format field selects single, double or paired single
`timescale 1ns/1ps
module fp_negate_and_negative_fused_ops
  import fp_negfused_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [63:0] fs_value,
  input  wire logic [63:0] ft_value,
  input  wire logic [63:0] fr_value,
  input  wire logic        fpu_enabled,
  input  wire logic [1:0]  round_mode,
  input  wire logic [4:0]  trap_enable,
  input  wire logic [4:0]  flag_clear,
  output logic             result_valid,
  output logic [63:0]      result_value,
  output logic [4:0]       result_dest,
  output logic [5:0]       cause_bits,
  output logic             fp_trap,
  output logic             cop_unusable_exc,
  output logic             reserved_instr_exc,
  output logic [4:0]       sticky_flags
);
  op_kind_t  d_op;
  fmt_kind_t d_fmt;
  logic      d_hit;
  logic      d_go;

  op_kind_t    s1_op_q;
  fmt_kind_t   s1_fmt_q;
  logic [4:0]  s1_dest_q;
  logic [1:0]  s1_rm_q;
  logic [63:0] s1_fr_q;
  logic        s1_cu_q;
  logic        s1_ri_q;

  logic [63:0] lane_res [0:2];
  logic [5:0]  lane_cs [0:2];
  logic [63:0] sel_res;
  logic [5:0]  sel_cs;
  logic        sel_trap;
  logic        s1_busy;

  logic        result_valid_q;
  logic [63:0] result_value_q;
  logic [4:0]  result_dest_q;
  logic [5:0]  cause_q;
  logic        fp_trap_q;
  logic        cop_unusable_q;
  logic        reserved_instr_q;
  logic [4:0]  flags_q;

  // decode
  always_comb begin
    d_op  = OP_NONE;
    d_fmt = FMT_BAD;
    if (instr_word[MAJOR_LSB +: 6] == FUSED_MAJOR &&
        (instr_word[FUNC3_LSB +: 3] == FN_NMADD ||
         instr_word[FUNC3_LSB +: 3] == FN_NMSUB)) begin
      d_op = (instr_word[FUNC3_LSB +: 3] == FN_NMADD) ? OP_NMADD : OP_NMSUB;
      case (instr_word[FMT3_LSB +: 3])
        FMT3_S:  d_fmt = FMT_SGL;
        FMT3_D:  d_fmt = FMT_DBL;
        FMT3_PS: d_fmt = FMT_PAIR;
        default: d_fmt = FMT_BAD;
      endcase
    end else if (instr_word[MAJOR_LSB +: 6] == COP1_MAJOR &&
                 instr_word[FUNC6_LSB +: 6] == NEG_FUNCT) begin
      d_op = OP_NEG;
      case (instr_word[FMT5_LSB +: 5])
        FMT5_S:  d_fmt = FMT_SGL;
        FMT5_D:  d_fmt = FMT_DBL;
        FMT5_PS: d_fmt = FMT_PAIR;
        default: d_fmt = FMT_BAD;
      endcase
    end
  end

  assign d_hit = issue_valid && (d_op != OP_NONE);
  assign d_go  = d_hit && fpu_enabled && (d_fmt != FMT_BAD);

  // issue stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_op_q   <= OP_NONE;
      s1_fmt_q  <= FMT_SGL;
      s1_dest_q <= 5'h00;
      s1_rm_q   <= RM_NEAR;
      s1_fr_q   <= 64'h0;
      s1_cu_q   <= 1'b0;
      s1_ri_q   <= 1'b0;
    end else begin
      s1_op_q   <= d_go ? d_op : OP_NONE;
      s1_fmt_q  <= d_fmt;
      s1_dest_q <= instr_word[FD_LSB +: 5];
      s1_rm_q   <= round_mode;
      s1_fr_q   <= fr_value;
      s1_cu_q   <= d_hit && !fpu_enabled;
      s1_ri_q   <= d_hit && fpu_enabled && (d_fmt == FMT_BAD);
    end
  end

  // lane 0 double, lane 1 upper single, lane 2 lower single
  for (genvar g = 0; g < 3; g++) begin : g_lane
    localparam int EW  = (g == 0) ? DBL_EW : SGL_EW;
    localparam int FW  = (g == 0) ? DBL_FW : SGL_FW;
    localparam int W   = EW + FW + 1;
    localparam int LSB = (g == 1) ? PAIR_HI_LSB : 0;
    localparam int X   = FW + 4;
    localparam int N   = FW + 2 + X;
    localparam logic [EW+2:0] BIAS = (EW+3)'((1 << (EW - 1)) - 1);
    localparam logic [W-1:0]  QNAN = {1'b0, {EW{1'b1}}, 1'b0, {(FW-1){1'b1}}};
    localparam logic [W-1:0]  INF  = {1'b0, {EW{1'b1}}, {FW{1'b0}}};

    logic [W-1:0]    a_v, b_v, mr_v, mul_v, s0_v, val_q, r_v, ar_v, add_v;
    logic            a_s, a_z, a_i, a_n, a_sn, a_d;
    logic            b_s, b_z, b_i, b_n, b_sn, b_d;
    logic            p_s, p_z, p_i, p_n, p_sn, p_d;
    logic            r_s, r_z, r_i, r_n, r_sn, r_d;
    logic [EW-1:0]   a_e, b_e, p_e, r_e, bg_e, sm_e, d_sh;
    logic [FW:0]     a_m, b_m, p_m, r_m, bg_m, sm_m, pm_m;
    logic [2*FW+1:0] prod;
    logic [EW+2:0]   pm_e, ad_e;
    logic            top, pm_g, pm_st, mr_o, mr_u, mr_x, ar_o, ar_u, ar_x;
    logic            swap, eff_sub, bg_s, zs;
    logic [5:0]      mul_c, s0_c, cs_q, add_c;
    logic [N-1:0]    op_a, op_b, sum, norm;
    int              msb;

    assign a_v = fs_value[LSB +: W];
    assign b_v = ft_value[LSB +: W];

    fp_classify_unit #(.EW(EW), .FW(FW)) u_cls_a (
      .value(a_v), .sign(a_s), .exp(a_e), .mant(a_m), .is_zero(a_z),
      .is_inf(a_i), .is_nan(a_n), .is_snan(a_sn), .is_denorm(a_d));
    fp_classify_unit #(.EW(EW), .FW(FW)) u_cls_b (
      .value(b_v), .sign(b_s), .exp(b_e), .mant(b_m), .is_zero(b_z),
      .is_inf(b_i), .is_nan(b_n), .is_snan(b_sn), .is_denorm(b_d));

    // product, rounded on its own
    assign prod  = a_m * b_m;
    assign top   = prod[2*FW+1];
    assign pm_m  = top ? prod[2*FW+1 -: FW+1] : prod[2*FW -: FW+1];
    assign pm_g  = top ? prod[FW] : prod[FW-1];
    assign pm_st = top ? |prod[FW-1:0] : |prod[FW-2:0];
    assign pm_e  = (EW+3)'(a_e) + (EW+3)'(b_e) - BIAS + (EW+3)'(top);

    fp_round_unit #(.EW(EW), .FW(FW)) u_rnd_mul (
      .rm(round_mode), .sign(a_s ^ b_s), .exp(pm_e), .mant(pm_m), .guard(pm_g),
      .sticky(pm_st), .force_zero(1'b0), .result(mr_v), .overflow(mr_o),
      .underflow(mr_u), .inexact(mr_x));

    always_comb begin
      mul_v        = mr_v;
      mul_c        = 6'h00;
      mul_c[C_O]   = mr_o;
      mul_c[C_U]   = mr_u;
      mul_c[C_I]   = mr_x;
      if (a_n || b_n) begin
        mul_v      = QNAN;
        mul_c      = 6'h00;
        mul_c[C_V] = a_sn | b_sn;
      end else if ((a_i && b_z) || (b_i && a_z)) begin
        mul_v      = QNAN;
        mul_c      = 6'h00;
        mul_c[C_V] = 1'b1;
      end else if (a_d || b_d) begin
        mul_v      = QNAN;
        mul_c      = 6'h00;
        mul_c[C_E] = 1'b1;
      end else if (a_i || b_i) begin
        mul_v      = INF | {a_s ^ b_s, {(W-1){1'b0}}};
        mul_c      = 6'h00;
      end else if (a_z || b_z) begin
        mul_v      = {a_s ^ b_s, {(W-1){1'b0}}};
        mul_c      = 6'h00;
      end
    end

    // sign-flip shares the first stage
    always_comb begin
      s0_v = mul_v;
      s0_c = mul_c;
      if (d_op == OP_NEG) begin
        s0_v      = {~a_s, a_v[W-2:0]};
        s0_c      = 6'h00;
        s0_c[C_V] = a_n;
        s0_c[C_E] = a_d;
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        val_q <= '0;
        cs_q  <= 6'h00;
      end else begin
        val_q <= s0_v;
        cs_q  <= s0_c;
      end
    end

    // addend, sign turned for subtract
    assign r_v = {s1_fr_q[LSB+W-1] ^ (s1_op_q == OP_NMSUB), s1_fr_q[LSB +: W-1]};

    fp_classify_unit #(.EW(EW), .FW(FW)) u_cls_p (
      .value(val_q), .sign(p_s), .exp(p_e), .mant(p_m), .is_zero(p_z),
      .is_inf(p_i), .is_nan(p_n), .is_snan(p_sn), .is_denorm(p_d));
    fp_classify_unit #(.EW(EW), .FW(FW)) u_cls_r (
      .value(r_v), .sign(r_s), .exp(r_e), .mant(r_m), .is_zero(r_z),
      .is_inf(r_i), .is_nan(r_n), .is_snan(r_sn), .is_denorm(r_d));

    assign swap    = {r_e, r_m} > {p_e, p_m};
    assign bg_e    = swap ? r_e : p_e;
    assign sm_e    = swap ? p_e : r_e;
    assign bg_m    = swap ? r_m : p_m;
    assign sm_m    = swap ? p_m : r_m;
    assign bg_s    = swap ? r_s : p_s;
    assign eff_sub = p_s ^ r_s;
    assign d_sh    = bg_e - sm_e;
    assign op_a    = {1'b0, bg_m, {X{1'b0}}};
    assign op_b    = (d_sh > EW'(X)) ? N'(1) : ({1'b0, sm_m, {X{1'b0}}} >> d_sh);
    assign sum     = eff_sub ? op_a - op_b : op_a + op_b;
    assign zs      = eff_sub && (s1_rm_q == RM_NINF);

    always_comb begin
      msb = 0;
      for (int i = 0; i < N; i++) begin
        if (sum[i]) begin
          msb = i;
        end
      end
    end

    assign norm = sum << (N - 1 - msb);
    assign ad_e = (EW+3)'(bg_e) + (EW+3)'(msb) - (EW+3)'(N - 2);

    fp_round_unit #(.EW(EW), .FW(FW)) u_rnd_add (
      .rm(s1_rm_q), .sign((sum == '0) ? zs : bg_s), .exp(ad_e),
      .mant(norm[N-1 -: FW+1]), .guard(norm[N-FW-2]), .sticky(|norm[N-FW-3:0]),
      .force_zero(sum == '0), .result(ar_v), .overflow(ar_o),
      .underflow(ar_u), .inexact(ar_x));

    always_comb begin
      add_v      = ar_v;
      add_c      = 6'h00;
      add_c[C_O] = ar_o;
      add_c[C_U] = ar_u;
      add_c[C_I] = ar_x;
      if (p_n || r_n) begin
        add_v      = QNAN;
        add_c      = 6'h00;
        add_c[C_V] = p_sn | r_sn;
      end else if (p_i && r_i && eff_sub) begin
        add_v      = QNAN;
        add_c      = 6'h00;
        add_c[C_V] = 1'b1;
      end else if (p_d || r_d) begin
        add_v      = QNAN;
        add_c      = 6'h00;
        add_c[C_E] = 1'b1;
      end else if (p_i || r_i) begin
        add_v      = p_i ? val_q : r_v;
        add_c      = 6'h00;
      end else if (p_z && r_z) begin
        add_v      = {eff_sub ? zs : p_s, {(W-1){1'b0}}};
        add_c      = 6'h00;
      end else if (p_z || r_z) begin
        add_v      = p_z ? r_v : val_q;
        add_c      = 6'h00;
      end
    end

    // final negate; causes of both steps accumulate
    assign lane_res[g] = 64'((s1_op_q == OP_NEG) ? val_q : {~add_v[W-1], add_v[W-2:0]});
    assign lane_cs[g]  = (s1_op_q == OP_NEG) ? cs_q : (cs_q | add_c);
  end

  // format select and pair merge
  always_comb begin
    case (s1_fmt_q)
      FMT_DBL: begin
        sel_res = lane_res[0];
        sel_cs  = lane_cs[0];
      end
      FMT_PAIR: begin
        sel_res = {lane_res[1][31:0], lane_res[2][31:0]};
        sel_cs  = lane_cs[1] | lane_cs[2];
      end
      default: begin
        sel_res = {32'h0, lane_res[2][31:0]};
        sel_cs  = lane_cs[2];
      end
    endcase
  end

  assign s1_busy  = (s1_op_q != OP_NONE);
  assign sel_trap = sel_cs[C_E] || |(sel_cs[C_V:C_I] & trap_enable);

  // result and exception outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      result_valid_q   <= 1'b0;
      result_value_q   <= 64'h0;
      result_dest_q    <= 5'h00;
      cause_q          <= 6'h00;
      fp_trap_q        <= 1'b0;
      cop_unusable_q   <= 1'b0;
      reserved_instr_q <= 1'b0;
    end else begin
      result_valid_q   <= s1_busy && !sel_trap;
      fp_trap_q        <= s1_busy && sel_trap;
      cop_unusable_q   <= s1_cu_q;
      reserved_instr_q <= s1_ri_q;
      if (s1_busy) begin
        result_value_q <= sel_res;
        result_dest_q  <= s1_dest_q;
        cause_q        <= sel_cs;
      end
    end
  end

  // sticky flags, a new cause wins over a clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~flag_clear) |
                 ((s1_busy && !sel_trap) ? sel_cs[C_V:C_I] : 5'h00);
    end
  end

  assign result_valid       = result_valid_q;
  assign result_value       = result_value_q;
  assign result_dest        = result_dest_q;
  assign cause_bits         = cause_q;
  assign fp_trap            = fp_trap_q;
  assign cop_unusable_exc   = cop_unusable_q;
  assign reserved_instr_exc = reserved_instr_q;
  assign sticky_flags       = flags_q;
endmodule

// File: hdl/fp_negfused_pkg.sv
// shared constants and types for the negate and negative fused datapath
package fp_negfused_pkg;
  // instruction word field positions
  localparam int MAJOR_LSB = 26;
  localparam int FR_LSB    = 21;
  localparam int FMT5_LSB  = 21;
  localparam int FT_LSB    = 16;
  localparam int FS_LSB    = 11;
  localparam int FD_LSB    = 6;
  localparam int FUNC3_LSB = 3;
  localparam int FMT3_LSB  = 0;
  localparam int FUNC6_LSB = 0;
  // opcode values
  localparam logic [5:0] FUSED_MAJOR = 6'h13;
  localparam logic [5:0] COP1_MAJOR  = 6'h11;
  localparam logic [5:0] NEG_FUNCT   = 6'h07;
  localparam logic [2:0] FN_NMADD    = 3'h6;
  localparam logic [2:0] FN_NMSUB    = 3'h7;
  // format codes
  localparam logic [2:0] FMT3_S  = 3'h0;
  localparam logic [2:0] FMT3_D  = 3'h1;
  localparam logic [2:0] FMT3_PS = 3'h6;
  localparam logic [4:0] FMT5_S  = 5'h10;
  localparam logic [4:0] FMT5_D  = 5'h11;
  localparam logic [4:0] FMT5_PS = 5'h16;
  // cause bit positions: E V Z O U I
  localparam int C_E = 5;
  localparam int C_V = 4;
  localparam int C_Z = 3;
  localparam int C_O = 2;
  localparam int C_U = 1;
  localparam int C_I = 0;
  // rounding modes
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_PINF = 2'h2;
  localparam logic [1:0] RM_NINF = 2'h3;
  // lane layouts
  localparam int DBL_EW      = 11;
  localparam int DBL_FW      = 52;
  localparam int SGL_EW      = 8;
  localparam int SGL_FW      = 23;
  localparam int PAIR_HI_LSB = 32;
  // reset values
  localparam logic [4:0] FLAGS_RST = 5'h00;
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_NEG   = 2'b01,
    OP_NMADD = 2'b10,
    OP_NMSUB = 2'b11
  } op_kind_t;
  typedef enum logic [1:0] {
    FMT_SGL  = 2'b00,
    FMT_DBL  = 2'b01,
    FMT_PAIR = 2'b10,
    FMT_BAD  = 2'b11
  } fmt_kind_t;
endpackage

// File: hdl/fp_round_unit.sv
// rounds a normalised mantissa to the lane format
`timescale 1ns/1ps
module fp_round_unit
  import fp_negfused_pkg::*;
#(
  parameter int EW = 8,
  parameter int FW = 23
) (
  input  wire logic [1:0]    rm,
  input  wire logic          sign,
  input  wire logic [EW+2:0] exp,
  input  wire logic [FW:0]   mant,
  input  wire logic          guard,
  input  wire logic          sticky,
  input  wire logic          force_zero,
  output logic [EW+FW:0]     result,
  output logic               overflow,
  output logic               underflow,
  output logic               inexact
);
  localparam logic [EW+2:0] EMAX = (EW+3)'((1 << EW) - 1);
  logic          up;
  logic          to_max;
  logic [FW+1:0] sum;
  logic [EW+2:0] e2;

  always_comb begin
    case (rm)
      RM_NEAR: up = guard & (sticky | mant[0]);
      RM_ZERO: up = 1'b0;
      RM_PINF: up = ~sign & (guard | sticky);
      default: up = sign & (guard | sticky);
    endcase
    sum       = {1'b0, mant} + {{(FW+1){1'b0}}, up};
    e2        = exp + (EW+3)'(sum[FW+1]);
    to_max    = (rm == RM_ZERO) | ((rm == RM_PINF) & sign) | ((rm == RM_NINF) & ~sign);
    overflow  = 1'b0;
    underflow = 1'b0;
    inexact   = guard | sticky;
    result    = {sign, e2[EW-1:0], sum[FW-1:0]};
    if (force_zero) begin
      inexact = 1'b0;
      result  = {sign, {(EW+FW){1'b0}}};
    end else if (!e2[EW+2] && e2 >= EMAX) begin
      overflow = 1'b1;
      inexact  = 1'b1;
      if (to_max) begin
        result = {sign, {(EW-1){1'b1}}, 1'b0, {FW{1'b1}}};
      end else begin
        result = {sign, {EW{1'b1}}, {FW{1'b0}}};
      end
    end else if (e2[EW+2] || e2 == '0) begin
      underflow = 1'b1;
      inexact   = 1'b1;
      result    = {sign, {(EW+FW){1'b0}}};
    end
  end
endmodule
